//--- rtl/mgmt_pkg.sv
package mgmt_pkg;

    // Timebase
    localparam int CLK_PERIOD_NS       = 40;
    localparam int INIT_TIME_MS        = 2000;
    localparam int RESET_PULSE_NS      = 2000;
    // Longest time, rounded down
    localparam int INIT_CYCLES         = (INIT_TIME_MS * 1000) / CLK_PERIOD_NS * 1000;
    // Least time, rounded up
    localparam int RESET_PULSE_CYCLES  = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CNT_W          = 26;
    localparam int PULSE_CNT_W         = 7;

    // Byte addresses of the management map
    localparam logic [7:0] ADDR_IDENT   = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h02;
    localparam logic [7:0] ADDR_FLAGS   = 8'h03;
    localparam logic [7:0] ADDR_CONTROL = 8'h5d;
    localparam logic [7:0] ADDR_MASK    = 8'h64;
    localparam logic [7:0] ADDR_PAGE    = 8'h7f;
    localparam int         UPPER_BIT    = 7;
    localparam logic [7:0] USER_PAGE    = 8'h02;

    // Field positions
    localparam int STATUS_NOT_READY_BIT = 0;
    localparam int CTRL_PDOWN_BIT       = 1;

    // Reset values
    localparam logic [3:0] MASK_RESET   = 4'h0;
    localparam logic [7:0] PAGE_RESET   = 8'h00;
    localparam logic       PDOWN_RESET  = 1'b0;
    // Arbitrary identifier value
    localparam logic [7:0] IDENT_VALUE  = 8'h5a;

    // Synchroniser lanes
    localparam int SYNC_W      = 7;
    localparam int SY_SCL      = 0;
    localparam int SY_SEL_N    = 1;
    localparam int SY_MRST_N   = 2;
    localparam int SY_LP_PIN   = 3;
    localparam int SY_RX_LOS   = 4;
    localparam int SY_TX_FAULT = 5;
    localparam int SY_OTHER    = 6;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 7'h06;

    // Latched flag byte, bits [3:0]
    typedef struct packed {
        logic ready;
        logic other;
        logic tx_fault;
        logic rx_los;
    } flag_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

endpackage : mgmt_pkg

//--- rtl/sync_bits.sv
`timescale 1ns/10ps
`default_nettype none

module sync_bits #(
    parameter int                    W         = 1,
    parameter logic [W-1:0]          RESET_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_lane
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_reg[i] <= RESET_VAL[i];
                    q_reg[i]    <= RESET_VAL[i];
                end
                else
                begin
                    meta_reg[i] <= d[i];
                    q_reg[i]    <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign q = q_reg;

endmodule : sync_bits

`default_nettype wire

//--- rtl/user_mem.sv
`timescale 1ns/10ps
`default_nettype none

module user_mem (
    input  wire logic       clk,
    input  wire logic       we,
    input  wire logic [6:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata
);

    // No reset: contents belong to the user
    logic [7:0] mem [0:127];
    logic [7:0] rdata_reg;

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata_reg <= mem[addr];
    end

    assign rdata = rdata_reg;

endmodule : user_mem

`default_nettype wire

//--- rtl/module_mgmt_status_timing.sv
// Operation
// - Fully functional within 2000 ms of power-on, plug-in or reset release.
// - A module reset pin low longer than 2 us resets the module.
// - Serial management access answered no later than 2000 ms after power-on.
// - Within 2000 ms, clear data-not-ready bit 0 of byte 2, assert interrupt.
// - After reset pin rises, fully functional within 2000 ms, interrupt asserted.
// - Low-power pin high drops the module to low power within 100 us.
// - Interrupt output driven low within 200 ms of a triggering condition.
// - Reading a flag clears it; interrupt released within 500 us.
// - Receive signal loss sets its flag and interrupt within 100 ms.
// - Transmit fault sets its flag and interrupt within 200 ms.
// - Any other condition sets its flag and interrupt within 200 ms.
// - Setting a mask bit inhibits that source within 100 ms.
// - Clearing a mask bit restores that source within 100 ms.
// - Module select asserted: serial transfers answered within 100 us.
// - Module select released: serial transfers ignored within 100 us.
// - Power-down bit set: low power within 100 ms.
// - Power-down bit cleared: full function within 300 ms.
// - Write-started delays count from serial clock fall after the write.
// - Upper page two is user storage with user-defined contents.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none

module module_mgmt_status_timing #(
    parameter int unsigned INIT_CYCLES = mgmt_pkg::INIT_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       serial_clk,
    input  wire logic       module_select_n,
    input  wire logic       module_reset_n,
    input  wire logic       low_power_pin,
    input  wire logic       rx_los_in,
    input  wire logic       tx_fault_in,
    input  wire logic       other_fault_in,
    output logic            interrupt_out_n_o,
    output logic            interrupt_out_n_oe_n,
    output logic            low_power_out,
    output logic            data_ready_out
);

    typedef enum logic [1:0] {
        ST_HELD,
        ST_INIT,
        ST_READY
    } init_state_t;

    // Reset release
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_sync_reg <= 2'b00;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    // Pin synchronisers
    logic [mgmt_pkg::SYNC_W-1:0] pins_raw;
    logic [mgmt_pkg::SYNC_W-1:0] pins_s;

    always_comb
    begin
        pins_raw                        = '0;
        pins_raw[mgmt_pkg::SY_SCL]      = serial_clk;
        pins_raw[mgmt_pkg::SY_SEL_N]    = module_select_n;
        pins_raw[mgmt_pkg::SY_MRST_N]   = module_reset_n;
        pins_raw[mgmt_pkg::SY_LP_PIN]   = low_power_pin;
        pins_raw[mgmt_pkg::SY_RX_LOS]   = rx_los_in;
        pins_raw[mgmt_pkg::SY_TX_FAULT] = tx_fault_in;
        pins_raw[mgmt_pkg::SY_OTHER]    = other_fault_in;
    end

    sync_bits #(
        .W         (mgmt_pkg::SYNC_W),
        .RESET_VAL (mgmt_pkg::SYNC_RESET)
    ) u_sync (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .d     (pins_raw),
        .q     (pins_s)
    );

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] target);
        is_addr = (a == target);
    endfunction : is_addr

    // State
    init_state_t                        state_reg,        state_next;
    logic [mgmt_pkg::INIT_CNT_W-1:0]    init_cnt_reg,     init_cnt_next;
    logic [mgmt_pkg::PULSE_CNT_W-1:0]   low_cnt_reg,      low_cnt_next;
    logic                               scl_d_reg;
    mgmt_pkg::flag_t                    flags_reg,        flags_next;
    logic [3:0]                         mask_shadow_reg,  mask_shadow_next;
    logic [3:0]                         mask_active_reg,  mask_active_next;
    logic                               pdown_shadow_reg, pdown_shadow_next;
    logic                               pdown_active_reg, pdown_active_next;
    logic                               commit_pend_reg,  commit_pend_next;
    logic [7:0]                         page_reg,         page_next;
    logic [7:0]                         rd_local_reg,     rd_local_next;
    logic                               rd_mem_reg,       rd_mem_next;
    logic                               int_oe_n_reg,     int_oe_n_next;
    logic                               low_power_reg,    low_power_next;
    logic                               ready_reg,        ready_next;

    mgmt_pkg::bus_req_t req;
    mgmt_pkg::flag_t    cond;
    mgmt_pkg::flag_t    flag_set;
    mgmt_pkg::flag_t    flag_clr;
    logic               scl_fall;
    logic               mrst_held;
    logic               bus_ok;
    logic               upper;
    logic               user_sel;
    logic               mem_we;
    logic [7:0]         mem_rdata;

    assign req      = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign scl_fall = scl_d_reg & ~pins_s[mgmt_pkg::SY_SCL];
    assign upper    = req.addr[mgmt_pkg::UPPER_BIT];
    assign user_sel = upper && (page_reg == mgmt_pkg::USER_PAGE);
    assign mrst_held = (low_cnt_reg == mgmt_pkg::PULSE_CNT_W'(mgmt_pkg::RESET_PULSE_CYCLES));
    assign bus_ok   = !pins_s[mgmt_pkg::SY_SEL_N] && (state_reg != ST_HELD);
    assign mem_we   = bus_ok && req.wr && user_sel;

    user_mem u_user_mem (
        .clk   (ref_clk),
        .we    (mem_we),
        .addr  (req.addr[6:0]),
        .wdata (req.wdata),
        .rdata (mem_rdata)
    );

    // Reset filter and initialisation sequence
    always_comb
    begin
        state_next    = state_reg;
        init_cnt_next = init_cnt_reg;
        low_cnt_next  = low_cnt_reg;
        ready_next    = ready_reg;
        if (pins_s[mgmt_pkg::SY_MRST_N])
        begin
            low_cnt_next = '0;
        end
        else if (!mrst_held)
        begin
            low_cnt_next = low_cnt_reg + 1'b1;
        end
        unique case (state_reg)
            ST_HELD:
            begin
                ready_next = 1'b0;
                if (pins_s[mgmt_pkg::SY_MRST_N])
                begin
                    state_next    = ST_INIT;
                    init_cnt_next = mgmt_pkg::INIT_CNT_W'(INIT_CYCLES - 1);
                end
            end
            ST_INIT:
            begin
                if (mrst_held)
                begin
                    state_next = ST_HELD;
                end
                else if (init_cnt_reg == '0)
                begin
                    state_next = ST_READY;
                    ready_next = 1'b1;
                end
                else
                begin
                    init_cnt_next = init_cnt_reg - 1'b1;
                end
            end
            ST_READY:
            begin
                if (mrst_held)
                begin
                    state_next = ST_HELD;
                    ready_next = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg    <= ST_INIT;
            init_cnt_reg <= mgmt_pkg::INIT_CNT_W'(INIT_CYCLES - 1);
            low_cnt_reg  <= '0;
            ready_reg    <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            init_cnt_reg <= init_cnt_next;
            low_cnt_reg  <= low_cnt_next;
            ready_reg    <= ready_next;
        end
    end

    // Flags, masks, control and bus
    always_comb
    begin
        cond          = '{ready: 1'b0,
                          other: pins_s[mgmt_pkg::SY_OTHER],
                          tx_fault: pins_s[mgmt_pkg::SY_TX_FAULT],
                          rx_los: pins_s[mgmt_pkg::SY_RX_LOS]};
        flag_set       = cond;
        flag_set.ready = (state_reg == ST_INIT) && (state_next == ST_READY);
        flag_clr       = '0;
        // Host read clears what it saw
        if (bus_ok && req.rd && is_addr(req.addr, mgmt_pkg::ADDR_FLAGS))
        begin
            flag_clr = flags_reg;
        end
        flags_next = mgmt_pkg::flag_t'((flags_reg & ~flag_clr) | flag_set);

        mask_shadow_next  = mask_shadow_reg;
        pdown_shadow_next = pdown_shadow_reg;
        page_next         = page_reg;
        commit_pend_next  = commit_pend_reg;
        mask_active_next  = mask_active_reg;
        pdown_active_next = pdown_active_reg;
        // Take effect at serial clock fall
        // Link clock idle keeps the change pending
        if (commit_pend_reg && scl_fall)
        begin
            commit_pend_next = 1'b0;
            mask_active_next  = mask_shadow_reg;
            pdown_active_next = pdown_shadow_reg;
        end
        // Write after commit: a colliding write stays pending
        if (bus_ok && req.wr && !upper)
        begin
            if (is_addr(req.addr, mgmt_pkg::ADDR_MASK))
            begin
                mask_shadow_next = req.wdata[3:0];
                commit_pend_next = 1'b1;
            end
            if (is_addr(req.addr, mgmt_pkg::ADDR_CONTROL))
            begin
                pdown_shadow_next = req.wdata[mgmt_pkg::CTRL_PDOWN_BIT];
                commit_pend_next  = 1'b1;
            end
            if (is_addr(req.addr, mgmt_pkg::ADDR_PAGE))
            begin
                page_next = req.wdata;
            end
        end

        rd_mem_next   = 1'b0;
        rd_local_next = '0;
        if (bus_ok && req.rd)
        begin
            if (upper)
            begin
                rd_mem_next = user_sel;
            end
            else if (is_addr(req.addr, mgmt_pkg::ADDR_IDENT))
            begin
                rd_local_next = mgmt_pkg::IDENT_VALUE;
            end
            else if (is_addr(req.addr, mgmt_pkg::ADDR_STATUS))
            begin
                rd_local_next[mgmt_pkg::STATUS_NOT_READY_BIT] = !ready_reg;
            end
            else if (is_addr(req.addr, mgmt_pkg::ADDR_FLAGS))
            begin
                rd_local_next[3:0] = flags_reg;
            end
            else if (is_addr(req.addr, mgmt_pkg::ADDR_MASK))
            begin
                rd_local_next[3:0] = mask_shadow_reg;
            end
            else if (is_addr(req.addr, mgmt_pkg::ADDR_CONTROL))
            begin
                rd_local_next[mgmt_pkg::CTRL_PDOWN_BIT] = pdown_shadow_reg;
            end
            else if (is_addr(req.addr, mgmt_pkg::ADDR_PAGE))
            begin
                rd_local_next = page_reg;
            end
        end

        // Hold while any unmasked flag set
        int_oe_n_next  = ~|(flags_reg & ~mask_active_reg);
        low_power_next = pins_s[mgmt_pkg::SY_LP_PIN] | pdown_active_reg;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_reg        <= '0;
            mask_shadow_reg  <= mgmt_pkg::MASK_RESET;
            mask_active_reg  <= mgmt_pkg::MASK_RESET;
            pdown_shadow_reg <= mgmt_pkg::PDOWN_RESET;
            pdown_active_reg <= mgmt_pkg::PDOWN_RESET;
            commit_pend_reg  <= 1'b0;
            page_reg         <= mgmt_pkg::PAGE_RESET;
            rd_local_reg     <= '0;
            rd_mem_reg       <= 1'b0;
            int_oe_n_reg     <= 1'b1;
            low_power_reg    <= 1'b0;
            scl_d_reg        <= 1'b0;
        end
        else if (state_reg == ST_HELD)
        begin
            // Module reset clears soft state, user storage survives
            flags_reg        <= '0;
            mask_shadow_reg  <= mgmt_pkg::MASK_RESET;
            mask_active_reg  <= mgmt_pkg::MASK_RESET;
            pdown_shadow_reg <= mgmt_pkg::PDOWN_RESET;
            pdown_active_reg <= mgmt_pkg::PDOWN_RESET;
            commit_pend_reg  <= 1'b0;
            page_reg         <= mgmt_pkg::PAGE_RESET;
            rd_local_reg     <= '0;
            rd_mem_reg       <= 1'b0;
            int_oe_n_reg     <= 1'b1;
            low_power_reg    <= low_power_next;
            scl_d_reg        <= pins_s[mgmt_pkg::SY_SCL];
        end
        else
        begin
            flags_reg        <= flags_next;
            mask_shadow_reg  <= mask_shadow_next;
            mask_active_reg  <= mask_active_next;
            pdown_shadow_reg <= pdown_shadow_next;
            pdown_active_reg <= pdown_active_next;
            commit_pend_reg  <= commit_pend_next;
            page_reg         <= page_next;
            rd_local_reg     <= rd_local_next;
            rd_mem_reg       <= rd_mem_next;
            int_oe_n_reg     <= int_oe_n_next;
            low_power_reg    <= low_power_next;
            scl_d_reg        <= pins_s[mgmt_pkg::SY_SCL];
        end
    end

    // Memory data is already registered inside the store
    assign reg_rdata            = rd_mem_reg ? mem_rdata : rd_local_reg;
    // Open drain: only ever pulls low
    assign interrupt_out_n_o    = 1'b0;
    assign interrupt_out_n_oe_n = int_oe_n_reg;
    assign low_power_out        = low_power_reg;
    assign data_ready_out       = ready_reg;

endmodule : module_mgmt_status_timing

`default_nettype wire

//--- test/module_mgmt_status_timing_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module module_mgmt_status_timing_checker #(
    parameter int unsigned INIT_CYCLES = 20
) (
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       serial_clk,
    input wire logic       module_select_n,
    input wire logic       module_reset_n,
    input wire logic       low_power_pin,
    input wire logic       rx_los_in,
    input wire logic       tx_fault_in,
    input wire logic       other_fault_in,
    input wire logic       interrupt_out_n_o,
    input wire logic       interrupt_out_n_oe_n,
    input wire logic       low_power_out,
    input wire logic       data_ready_out
);
    // Margin covers sync stages and reset release
    localparam int INIT_MAX = INIT_CYCLES + 12;
    logic [15:0] low_cnt;
    logic [15:0] cyc;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            low_cnt <= '0;
            cyc     <= '0;
        end
        else
        begin
            low_cnt <= module_reset_n ? 16'h0000 : low_cnt + {15'h0000, low_cnt != 16'hffff};
            cyc     <= cyc + {15'h0000, cyc != 16'hffff};
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    chk_init_bound: assert property (cyc == 16'(INIT_MAX) |-> data_ready_out)
        else $error("not ready after init time");
    chk_reinit_bound: assert property ($rose(module_reset_n) && $past(low_cnt) >= 16'h003a
        |-> ##[1:INIT_MAX] data_ready_out) else $error("not ready after module reset");
    chk_ready_int: assert property ($rose(data_ready_out) |-> ##[0:2] !interrupt_out_n_oe_n)
        else $error("no interrupt at ready");
    chk_held_state: assert property (low_cnt >= 16'h003a |-> !data_ready_out && interrupt_out_n_oe_n)
        else $error("long reset pulse not honoured");
    chk_no_early: assert property ($fell(data_ready_out) |-> low_cnt >= 16'h0032 || low_power_out)
        else $error("ready dropped without long reset");
    chk_lp_pin: assert property (low_power_pin [*6] |-> low_power_out)
        else $error("low power pin not followed");
    chk_rx_int: assert property ((rx_los_in && module_reset_n) [*6] |-> !interrupt_out_n_oe_n)
        else $error("signal loss without interrupt");
    chk_tx_int: assert property ((tx_fault_in && module_reset_n) [*6] |-> !interrupt_out_n_oe_n)
        else $error("transmit fault without interrupt");
    chk_read_release: assert property ((!rx_los_in && !tx_fault_in && !other_fault_in
        && !module_select_n && module_reset_n) [*5] ##0 (reg_rd && reg_addr == mgmt_pkg::ADDR_FLAGS)
        |-> ##2 interrupt_out_n_oe_n) else $error("interrupt kept after flag read");
    chk_sel_refuse: assert property (module_select_n [*5] ##0 reg_rd |=> reg_rdata == 8'h00)
        else $error("answered while deselected");

    cov_ready: cover property ($rose(data_ready_out));
    cov_int: cover property ($fell(interrupt_out_n_oe_n));
    cov_low_power: cover property ($rose(low_power_out));
endmodule : module_mgmt_status_timing_checker

bind module_mgmt_status_timing module_mgmt_status_timing_checker #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_clk(serial_clk),
    .module_select_n(module_select_n), .module_reset_n(module_reset_n),
    .low_power_pin(low_power_pin), .rx_los_in(rx_los_in), .tx_fault_in(tx_fault_in),
    .other_fault_in(other_fault_in), .interrupt_out_n_o(interrupt_out_n_o),
    .interrupt_out_n_oe_n(interrupt_out_n_oe_n), .low_power_out(low_power_out),
    .data_ready_out(data_ready_out));

`default_nettype wire

//--- test/host_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

module host_ctrl_model (
    input  wire logic ref_clk,
    input  wire logic frame_req,
    output logic      serial_clk
);
    // Idles high like a pulled-up bus clock, runs only inside a frame
    initial
    begin
        serial_clk = 1'b1;
        forever
        begin
            @(posedge ref_clk iff frame_req);
            #13;
            repeat (9)
            begin
                serial_clk = 1'b0;
                #160;
                serial_clk = 1'b1;
                #160;
            end
        end
    end
endmodule : host_ctrl_model

`default_nettype wire

//--- test/module_mgmt_status_timing_bench.sv
`timescale 1ns/10ps
`default_nettype none

module module_mgmt_status_timing_bench;
    localparam int unsigned INIT_N = 20;
    logic       ref_clk, reset_n, reg_wr, reg_rd, serial_clk, frame_req;
    logic       module_select_n, module_reset_n, low_power_pin;
    logic       interrupt_out_n_o, interrupt_out_n_oe_n, low_power_out, data_ready_out;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
    logic [2:0] cond;
    logic       int_pin;
    int         err_count, num_checks;

    // Open-drain pin as the host sees it
    assign int_pin = interrupt_out_n_oe_n ? 1'b1 : interrupt_out_n_o;

    module_mgmt_status_timing #(.INIT_CYCLES(INIT_N)) dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_clk(serial_clk),
        .module_select_n(module_select_n), .module_reset_n(module_reset_n),
        .low_power_pin(low_power_pin), .rx_los_in(cond[0]), .tx_fault_in(cond[1]),
        .other_fault_in(cond[2]), .interrupt_out_n_o(interrupt_out_n_o),
        .interrupt_out_n_oe_n(interrupt_out_n_oe_n), .low_power_out(low_power_out),
        .data_ready_out(data_ready_out));

    host_ctrl_model host (.ref_clk(ref_clk), .frame_req(frame_req), .serial_clk(serial_clk));

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        // Read before this edge's update lands
        @(posedge ref_clk);
        rd_val = reg_rdata;
        cmp(rd_val, exp);
    endtask : rdchk

    // Serial frame long enough for the pending write to commit
    task automatic frame;
        frame_req <= 1'b1;
        @(posedge ref_clk);
        frame_req <= 1'b0;
        cyc(80);
    endtask : frame

    task automatic wait_ready;
        for (int i = 0; i < INIT_N + 20 && data_ready_out !== 1'b1; i++)
            @(posedge ref_clk);
    endtask : wait_ready

    task automatic t_init;
        cyc(5);
        rdchk(mgmt_pkg::ADDR_STATUS, 8'h01);
        wait_ready();
        cmp(data_ready_out, 1'b1);
        rdchk(mgmt_pkg::ADDR_STATUS, 8'h00);
        rdchk(mgmt_pkg::ADDR_IDENT, mgmt_pkg::IDENT_VALUE);
        cmp(int_pin, 1'b0);
        rdchk(mgmt_pkg::ADDR_FLAGS, 8'h08);
        cyc(3);
        cmp(int_pin, 1'b1);
    endtask : t_init

    task automatic t_flags;
        for (int i = 0; i < 3; i++)
        begin
            cond <= 3'b001 << i;
            cyc(6);
            cmp(int_pin, 1'b0);
            cond <= 3'b000;
            cyc(4);
            cmp(int_pin, 1'b0);
            rdchk(mgmt_pkg::ADDR_FLAGS, 8'h01 << i);
            cyc(3);
            cmp(int_pin, 1'b1);
            rdchk(mgmt_pkg::ADDR_FLAGS, 8'h00);
        end
    endtask : t_flags

    task automatic t_mask;
        wr(mgmt_pkg::ADDR_MASK, 8'h04);
        rdchk(mgmt_pkg::ADDR_MASK, 8'h04);
        frame();
        cond <= 3'b100;
        cyc(6);
        cond <= 3'b000;
        cyc(4);
        cmp(int_pin, 1'b1);
        wr(mgmt_pkg::ADDR_MASK, 8'h00);
        cyc(10);
        cmp(int_pin, 1'b1);
        frame();
        cmp(int_pin, 1'b0);
        rdchk(mgmt_pkg::ADDR_FLAGS, 8'h04);
        cyc(3);
        cmp(int_pin, 1'b1);
    endtask : t_mask

    task automatic t_power;
        low_power_pin <= 1'b1;
        cyc(5);
        cmp(low_power_out, 1'b1);
        low_power_pin <= 1'b0;
        cyc(5);
        cmp(low_power_out, 1'b0);
        wr(mgmt_pkg::ADDR_CONTROL, 8'h02);
        cyc(10);
        cmp(low_power_out, 1'b0);
        frame();
        cmp(low_power_out, 1'b1);
        rdchk(mgmt_pkg::ADDR_CONTROL, 8'h02);
        wr(mgmt_pkg::ADDR_CONTROL, 8'h00);
        frame();
        cmp(low_power_out, 1'b0);
        cmp(data_ready_out, 1'b1);
    endtask : t_power

    task automatic t_select;
        module_select_n <= 1'b1;
        cyc(5);
        rdchk(mgmt_pkg::ADDR_IDENT, 8'h00);
        wr(mgmt_pkg::ADDR_MASK, 8'h0f);
        module_select_n <= 1'b0;
        cyc(5);
        rdchk(mgmt_pkg::ADDR_MASK, 8'h00);
        rdchk(mgmt_pkg::ADDR_IDENT, mgmt_pkg::IDENT_VALUE);
        rdchk(8'h50, 8'h00);
        wr(mgmt_pkg::ADDR_PAGE, mgmt_pkg::USER_PAGE);
        wr(8'h80, 8'h3c);
        rdchk(8'h80, 8'h3c);
        wr(mgmt_pkg::ADDR_PAGE, 8'h00);
        rdchk(8'h80, 8'h00);
    endtask : t_select

    task automatic t_modreset;
        module_reset_n <= 1'b0;
        cyc(30);
        module_reset_n <= 1'b1;
        cyc(5);
        cmp(data_ready_out, 1'b1);
        // Page must be seen cleared by the long pulse
        wr(mgmt_pkg::ADDR_PAGE, mgmt_pkg::USER_PAGE);
        module_reset_n <= 1'b0;
        cyc(70);
        cmp(data_ready_out, 1'b0);
        rdchk(mgmt_pkg::ADDR_IDENT, 8'h00);
        module_reset_n <= 1'b1;
        cyc(1);
        wait_ready();
        cmp(data_ready_out, 1'b1);
        cyc(3);
        cmp(int_pin, 1'b0);
        rdchk(mgmt_pkg::ADDR_PAGE, 8'h00);
        rdchk(mgmt_pkg::ADDR_FLAGS, 8'h08);
    endtask : t_modreset

    initial
    begin
        err_count = 0;
        num_checks = 0;
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        frame_req = 1'b0;
        module_select_n = 1'b0;
        module_reset_n = 1'b1;
        low_power_pin = 1'b0;
        cond = 3'b000;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_init();
        t_flags();
        t_mask();
        t_power();
        t_select();
        t_modreset();
        end_sim();
    end

    // Whole run needs about 670 cycles
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        end_sim();
    end
endmodule : module_mgmt_status_timing_bench

`default_nettype wire
